/* rtl/osc_start_timer.sv */
// start-up timer for the external oscillator supply
// assumes oscReq is synchronous to sys_clk and clkSeen already synchronised
`timescale 1ns/100ps
module osc_start_timer
   import radio_irq_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // control
   input wire logic oscReq,
   input wire logic [23:0] delaySteps,
   input wire logic clkSeen,
   // results
   output logic clkReady,
   output logic startErrPulse
);

   // ----------------------------------------------------------------------
   // step prescaler and step counter
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {T_OFF, T_WAIT, T_DONE} tstate_t;
   tstate_t state, next_state;
   logic [STEP_CNT_W-1:0] pre, next_pre;
   logic [23:0] steps, next_steps;
   logic next_err;
   logic errQ;

   // the clock stays gated while counting; expiry checks the clock presence
   always_comb begin
      next_state = state;
      next_pre = pre;
      next_steps = steps;
      next_err = 1'b0;
      unique case (state)
         T_OFF: begin
            next_pre = '0;
            next_steps = delaySteps;
            if (oscReq) begin
               next_state = T_WAIT;
            end
         end
         T_WAIT: begin
            if (!oscReq) begin
               next_state = T_OFF;
            end else if (steps == 24'h000000) begin
               next_state = T_DONE;
               next_err = !clkSeen;
            end else if (pre == STEP_CNT_W'(OSC_STEP_CYCLES - 1)) begin
               next_pre = '0;
               next_steps = steps - 24'h000001;
            end else begin
               next_pre = pre + STEP_CNT_W'(1);
            end
         end
         T_DONE: begin
            if (!oscReq) begin
               next_state = T_OFF;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state <= T_OFF;
         pre <= '0;
         steps <= OSC_DELAY_RESET;
         errQ <= 1'b0;
      end else begin
         state <= next_state;
         pre <= next_pre;
         steps <= next_steps;
         errQ <= next_err;
      end
   end

   assign clkReady = (state == T_DONE);
   assign startErrPulse = errQ;

endmodule

/* rtl/radio_irq_pin_and_osc_ctrl.sv */
// event log, pin routing, antenna switch and oscillator supply control
// assumes an spi slave with spiClk, spiCsN, spiMosi as async pins (mode 0)
//
// Summary of operation
// - opcode 08h then enable mask and three pin masks, msb first
// - all enable bits zero after reset; a one enables its source
// - pin high only if source enabled globally and routed to it
// - rising edge of enabled source logs flag; pins follow same cycle
// - each pin is the or of its routed flags
// - ten-bit log; upper status bits read as zero
// - bits: tx, rx, preamble, sync, hdr ok, hdr bad, crc, scan, cad, timeout
// - sync only in fsk mode; header, scan and cad only in chirp mode
// - opcode 12h, status in byte 1, log in bytes 2 and 3
// - opcode 02h then sixteen-bit clear word, msb first
// - each one in the clear word clears that flag only
// - pin stays high until all its routed flags are cleared
// - pins taken over by switch or oscillator carry no events
// - switch command byte: 0 leaves pin two as event, 1 takes it
// - switch pin high only in transmit mode
// - opcode 97h then voltage code and 24-bit delay, msb first
// - oscillator supply on in standby crystal, synth, tx, rx; hold core
// - three-bit voltage code latched and forwarded
// - wait delay times 15.625 us with oscillator clock gated
// - at the end ungate the clock and release the sequencer
// - no clock at delay end sets the start error flag
// - start error raised at cold start if supply assigned; host clears with error clear
`timescale 1ns/100ps
module radio_irq_pin_and_osc_ctrl
   import radio_irq_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // spi pins from the host
   input wire logic spiClk,
   input wire logic spiCsN,
   input wire logic spiMosi,
   output logic spiMiso,
   // radio core side
   input wire logic [9:0] eventSrc,
   input wire logic chirpMode,
   input wire radio_mode_t radioMode,
   input wire logic [7:0] chipStatus,
   input wire logic oscClkPresent,
   input wire logic coldStart,
   // event and dedicated pins
   output logic eventPinOne,
   output logic eventPinTwo,
   output logic eventPinThree,
   output logic [2:0] oscSupplyCode,
   output logic oscClkEnable,
   output logic seqHold,
   output logic oscStartError
);

   // ----------------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------------
   logic [2:0] syncA, syncB;
   logic sckPrev;
   logic sckRise, sckFall, csActive, mosiBit;

   // two flops on every pin; reset to idle levels so no false sck edge
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         syncA <= 3'h2;
         syncB <= 3'h2;
         sckPrev <= 1'b0;
      end else begin
         syncA <= {spiClk, spiCsN, spiMosi};
         syncB <= syncA;
         sckPrev <= syncB[2];
      end
   end

   assign csActive = !syncB[1];
   assign mosiBit = syncB[0];
   assign sckRise = csActive && syncB[2] && !sckPrev;
   assign sckFall = csActive && !syncB[2] && sckPrev;

   // ----------------------------------------------------------------------
   // spi byte framing
   // ----------------------------------------------------------------------
   logic [2:0] bitCnt, next_bitCnt;
   logic [7:0] shiftIn, next_shiftIn;
   logic [3:0] byteIdx, next_byteIdx;
   logic [7:0] opcode, next_opcode;
   logic [71:0] args, next_args;
   logic byteDone;
   logic [7:0] rxByte;

   assign rxByte = {shiftIn[6:0], mosiBit};
   assign byteDone = sckRise && (bitCnt == 3'h7);

   always_comb begin
      next_bitCnt = bitCnt;
      next_shiftIn = shiftIn;
      next_byteIdx = byteIdx;
      next_opcode = opcode;
      next_args = args;
      if (!csActive) begin
         next_bitCnt = 3'h0;
         next_byteIdx = 4'h0;
      end else if (sckRise) begin
         next_bitCnt = bitCnt + 3'h1;
         next_shiftIn = rxByte;
         if (bitCnt == 3'h7) begin
            if (byteIdx == 4'h0) begin
               next_opcode = rxByte;
            end else begin
               next_args = {args[63:0], rxByte}; // msb first
            end
            if (byteIdx != 4'(CMD_BYTES_MAX)) begin
               next_byteIdx = byteIdx + 4'h1;
            end
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         bitCnt <= 3'h0;
         shiftIn <= 8'h00;
         byteIdx <= 4'h0;
         opcode <= 8'h00;
         args <= '0;
      end else begin
         bitCnt <= next_bitCnt;
         shiftIn <= next_shiftIn;
         byteIdx <= next_byteIdx;
         opcode <= next_opcode;
         args <= next_args;
      end
   end

   // the command acts once its last argument byte lands, not at deselect
   logic cmdRouting, cmdClear, cmdOsc, cmdSwitch, cmdErrClr;
   assign cmdRouting = byteDone && opcode == OP_IRQ_ROUTING_CONFIG &&
      byteIdx == 4'h8;
   assign cmdClear = byteDone && opcode == OP_EVENT_LOG_CLEAR &&
      byteIdx == 4'h2;
   assign cmdOsc = byteDone && opcode == OP_OSC_SUPPLY_ASSIGN &&
      byteIdx == 4'h4;
   assign cmdSwitch = byteDone && opcode == OP_ANTENNA_SWITCH_ASSIGN &&
      byteIdx == 4'h1;
   assign cmdErrClr = byteDone && byteIdx == 4'h0 && rxByte == OP_ERROR_CLEAR;

   // ----------------------------------------------------------------------
   // configuration state
   // ----------------------------------------------------------------------
   routing_cfg_t routeCfg, next_routeCfg;
   osc_cfg_t oscCfg, next_oscCfg;
   logic switchMode, next_switchMode;

   always_comb begin
      next_routeCfg = routeCfg;
      next_oscCfg = oscCfg;
      next_switchMode = switchMode;
      if (cmdRouting) begin
         next_routeCfg = {args[55:0], rxByte};
      end
      if (cmdOsc) begin
         next_oscCfg.assigned = 1'b1;
         next_oscCfg.supplyCode = args[18:16];
         next_oscCfg.delaySteps = {args[15:0], rxByte};
      end
      if (cmdSwitch) begin
         next_switchMode = rxByte[0];
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         routeCfg <= {MASK_RESET, MASK_RESET, MASK_RESET, MASK_RESET};
         oscCfg <= {1'b0, OSC_CODE_RESET, OSC_DELAY_RESET};
         switchMode <= 1'b0;
      end else begin
         routeCfg <= next_routeCfg;
         oscCfg <= next_oscCfg;
         switchMode <= next_switchMode;
      end
   end

   // ----------------------------------------------------------------------
   // event log
   // ----------------------------------------------------------------------
   logic [9:0] srcPrev, eventLog, next_eventLog;
   logic [9:0] modeAllowed, setMask, clrMask;

   // sources bound to one packet mode are blocked in the other
   assign modeAllowed = chirpMode ? ~FSK_ONLY_SOURCES : ~CHIRP_ONLY_SOURCES;
   assign setMask = eventSrc & ~srcPrev & modeAllowed &
      routeCfg.globalEnable[9:0];
   assign clrMask = cmdClear ? {args[1:0], rxByte} : 10'h000;

   // set applied after clear so a coincident event survives
   always_comb begin
      next_eventLog = (eventLog & ~clrMask) | setMask;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         eventLog <= LOG_RESET;
         srcPrev <= 10'h000;
      end else begin
         eventLog <= next_eventLog;
         srcPrev <= eventSrc;
      end
   end

   // ----------------------------------------------------------------------
   // status read shifter
   // ----------------------------------------------------------------------
   logic [23:0] readShift, next_readShift;
   logic next_miso;

   // load on opcode, then shift out on each falling edge
   always_comb begin
      next_readShift = readShift;
      next_miso = spiMiso;
      if (!csActive) begin
         next_miso = 1'b0;
      end else if (byteDone && byteIdx == 4'h0 &&
            rxByte == OP_EVENT_LOG_READ) begin
         next_readShift = {chipStatus, 6'h00, eventLog};
      end else if (sckFall && byteIdx != 4'h0) begin
         next_miso = readShift[23];
         next_readShift = {readShift[22:0], 1'b0};
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         readShift <= 24'h000000;
         spiMiso <= 1'b0;
      end else begin
         readShift <= next_readShift;
         spiMiso <= next_miso;
      end
   end

   // ----------------------------------------------------------------------
   // oscillator supply and start-up
   // ----------------------------------------------------------------------
   logic [1:0] clkSync;
   logic oscReq, clkReady, errPulse, startErr, next_startErr;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         clkSync <= 2'b00;
      end else begin
         clkSync <= {clkSync[0], oscClkPresent};
      end
   end

   assign oscReq = oscCfg.assigned && needs_osc(radioMode);

   osc_start_timer timer (
      .sys_clk(sys_clk),
      .rst(rst),
      .oscReq(oscReq),
      .delaySteps(oscCfg.delaySteps),
      .clkSeen(clkSync[1]),
      .clkReady(clkReady),
      .startErrPulse(errPulse)
   );

   // set wins over the host clear; cold start raises it too while the supply is assigned
   always_comb begin
      next_startErr = startErr;
      if (cmdErrClr) begin
         next_startErr = 1'b0;
      end
      if (errPulse || (coldStart && oscCfg.assigned)) begin
         next_startErr = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         startErr <= 1'b0;
      end else begin
         startErr <= next_startErr;
      end
   end

   // ----------------------------------------------------------------------
   // pin outputs
   // ----------------------------------------------------------------------
   logic [9:0] live;
   assign live = eventLog & routeCfg.globalEnable[9:0];
   assign eventPinOne = |(live & routeCfg.pin1Mask[9:0]);
   assign eventPinTwo = switchMode ? (radioMode == MODE_TRANSMIT)
      : |(live & routeCfg.pin2Mask[9:0]);
   assign eventPinThree = oscCfg.assigned ? oscReq
      : |(live & routeCfg.pin3Mask[9:0]);
   assign oscSupplyCode = oscCfg.supplyCode;
   assign oscClkEnable = !oscCfg.assigned || clkReady;
   assign seqHold = oscReq && !clkReady;
   assign oscStartError = startErr;

endmodule

/* rtl/radio_irq_pkg.sv */
// package for the radio event logging, pin routing and oscillator control
// assumes a single 20 MHz system clock domain for all users
package radio_irq_pkg;

   // ----------------------------------------------------------------------
   // command opcodes
   // ----------------------------------------------------------------------
   localparam logic [7:0] OP_IRQ_ROUTING_CONFIG = 8'h08;
   localparam logic [7:0] OP_EVENT_LOG_READ = 8'h12;
   localparam logic [7:0] OP_EVENT_LOG_CLEAR = 8'h02;
   localparam logic [7:0] OP_OSC_SUPPLY_ASSIGN = 8'h97;
   localparam logic [7:0] OP_ANTENNA_SWITCH_ASSIGN = 8'h9D;
   localparam logic [7:0] OP_ERROR_CLEAR = 8'h07;

   // ----------------------------------------------------------------------
   // event log layout
   // ----------------------------------------------------------------------
   localparam int LOG_WIDTH = 10;
   localparam int BIT_TRANSMIT_COMPLETE = 0;
   localparam int BIT_PACKET_RECEIVED = 1;
   localparam int BIT_PREAMBLE_FOUND = 2;
   localparam int BIT_SYNC_MATCH = 3;
   localparam int BIT_HEADER_OK = 4;
   localparam int BIT_HEADER_BAD = 5;
   localparam int BIT_CHECK_FAIL = 6;
   localparam int BIT_SCAN_FINISHED = 7;
   localparam int BIT_ACTIVITY_FOUND = 8;
   localparam int BIT_TIMEOUT = 9;
   localparam logic [9:0] FSK_ONLY_SOURCES = 10'h008;
   localparam logic [9:0] CHIRP_ONLY_SOURCES = 10'h1B0;
   localparam logic [9:0] LOG_RESET = 10'h000;
   localparam logic [15:0] MASK_RESET = 16'h0000;
   localparam logic [2:0] OSC_CODE_RESET = 3'h0;
   localparam logic [23:0] OSC_DELAY_RESET = 24'h000000;

   // ----------------------------------------------------------------------
   // timing: one delay step in ps and in system clocks
   // ----------------------------------------------------------------------
   localparam int SYS_CLK_PERIOD_NS = 50;
   localparam int OSC_STEP_PS = 15625000;
   localparam int OSC_STEP_CYCLES =
      (OSC_STEP_PS + SYS_CLK_PERIOD_NS * 1000 - 1) / (SYS_CLK_PERIOD_NS * 1000);
   localparam int STEP_CNT_W = 9;
   localparam int CMD_BYTES_MAX = 9;

   // ----------------------------------------------------------------------
   // radio operating modes as reported by the mode sequencer
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_SLEEP, MODE_RC_STANDBY, MODE_CRYSTAL_STANDBY,
      MODE_SYNTH_READY, MODE_TRANSMIT, MODE_RECEIVE
   } radio_mode_t;

   // routing configuration carried together
   typedef struct packed {
      logic [15:0] globalEnable;
      logic [15:0] pin1Mask;
      logic [15:0] pin2Mask;
      logic [15:0] pin3Mask;
   } routing_cfg_t;

   // oscillator supply configuration
   typedef struct packed {
      logic assigned;
      logic [2:0] supplyCode;
      logic [23:0] delaySteps;
   } osc_cfg_t;

   // true when the mode needs the external oscillator powered
   function automatic logic needs_osc(radio_mode_t m);
      return (m == MODE_CRYSTAL_STANDBY) || (m == MODE_SYNTH_READY) ||
             (m == MODE_TRANSMIT) || (m == MODE_RECEIVE);
   endfunction

endpackage

/* verif/radio_irq_monitor.sv */
// concurrent checks on the event, switch and oscillator pins
// assumes binding onto the top module, one sys_clk domain
`timescale 1ns/100ps
module radio_irq_monitor
   import radio_irq_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // spi
   input wire logic spiCsN,
   input wire logic spiMiso,
   // core side
   input wire logic [9:0] eventSrc,
   input wire logic oscClkPresent,
   input wire logic coldStart,
   // pins
   input wire logic eventPinOne,
   input wire logic eventPinTwo,
   input wire logic eventPinThree,
   input wire logic [2:0] oscSupplyCode,
   input wire logic oscClkEnable,
   input wire logic seqHold,
   input wire logic oscStartError
);
   // ----
   // properties
   // ----
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   // event pins, start error and miso quiet right after reset
   reset_state_a: assert property ($fell(rst) |-> !eventPinOne &&
      !eventPinTwo && !eventPinThree && !oscStartError && !spiMiso)
      else $error("pins not idle after reset");
   miso_idle_a: assert property (spiCsN [*5] |-> !spiMiso)
      else $error("miso driven while deselected");
   // pin one rises only from a new source edge or a command
   pin_rise_a: assert property ($rose(eventPinOne) |->
      (($past(eventSrc) & ~$past(eventSrc, 2)) != 10'h000) ||
      !$past(spiCsN)) else $error("pin one rose without cause");
   pin_fall_a: assert property ($fell(eventPinOne) |->
      !$past(spiCsN)) else $error("pin one fell without clear");
   hold_gates_a: assert property (seqHold |->
      !oscClkEnable && eventPinThree)
      else $error("clock not gated during wait");
   clock_release_a: assert property ($fell(seqHold) &&
      eventPinThree &&
      oscClkPresent |-> oscClkEnable) else $error("clock not released");
   code_stable_a: assert property (!$stable(oscSupplyCode) |->
      !$past(spiCsN)) else $error("supply code moved without command");
   err_rise_a: assert property ($rose(oscStartError) |->
      !$past(oscClkPresent, 3) || $past(coldStart) || $past(coldStart, 2))
      else $error("start error without cause");
   err_fall_a: assert property ($fell(oscStartError) |->
      !$past(spiCsN)) else $error("start error cleared without command");
endmodule

bind radio_irq_pin_and_osc_ctrl radio_irq_monitor u_radio_irq_monitor (
   .sys_clk(sys_clk), .rst(rst), .spiCsN(spiCsN), .spiMiso(spiMiso),
   .eventSrc(eventSrc), .oscClkPresent(oscClkPresent),
   .coldStart(coldStart), .eventPinOne(eventPinOne),
   .eventPinTwo(eventPinTwo), .eventPinThree(eventPinThree),
   .oscSupplyCode(oscSupplyCode), .oscClkEnable(oscClkEnable),
   .seqHold(seqHold), .oscStartError(oscStartError));

/* verif/spi_host_model.sv */
// host side spi master, mode 0, 400 ns bit period
// assumes the device samples on rise and shifts miso after fall
`timescale 1ns/100ps
module spi_host_model (
   // spi pins
   output logic spiClk,
   output logic spiCsN,
   output logic spiMosi,
   input wire logic spiMiso
);
   // ----
   // frame engine
   // ----
   initial begin
      spiClk = 1'b0;
      spiCsN = 1'b1;
      spiMosi = 1'b0;
   end

   // whole frame, msb of first byte first
   task automatic xfer(input logic [71:0] tx, input int n,
                       output logic [71:0] rx);
      rx = '0;
      spiCsN = 1'b0;
      for (int i = 8 * n - 1; i >= 0; i--) begin
         spiMosi = tx[i];
         #200 spiClk = 1'b1;
         rx = {rx[70:0], spiMiso};
         #200 spiClk = 1'b0;
      end
      #200 spiCsN = 1'b1;
      spiMosi = ~spiMosi; // released line must not keep its last value
      #800;
   endtask
endmodule

/* verif/tb_top.sv */
// self-checking bench for event log, routing and oscillator control
// assumes the host model handles all spi framing
`timescale 1ns/100ps
module tb_top;
   import radio_irq_pkg::*;
   // ----
   // signals
   // ----
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic spiClk, spiCsN, spiMosi, spiMiso;
   logic [9:0] eventSrc = 10'h000;
   logic chirpMode = 1'b0;
   radio_mode_t radioMode = MODE_RC_STANDBY;
   logic [7:0] chipStatus = 8'hA5;
   logic oscClkPresent = 1'b1;
   logic coldStart = 1'b0;
   logic eventPinOne, eventPinTwo, eventPinThree, oscClkEnable;
   logic seqHold, oscStartError;
   logic [2:0] oscSupplyCode;
   logic [71:0] rx;
   logic [9:0] allowed;
   int mismatches = 0;
   int total_checks = 0;
   int cnt;

   always #25 sys_clk = ~sys_clk;

   radio_irq_pin_and_osc_ctrl u_radio_irq_pin_and_osc_ctrl (
      .sys_clk(sys_clk), .rst(rst), .spiClk(spiClk), .spiCsN(spiCsN),
      .spiMosi(spiMosi), .spiMiso(spiMiso), .eventSrc(eventSrc),
      .chirpMode(chirpMode), .radioMode(radioMode),
      .chipStatus(chipStatus), .oscClkPresent(oscClkPresent),
      .coldStart(coldStart), .eventPinOne(eventPinOne),
      .eventPinTwo(eventPinTwo), .eventPinThree(eventPinThree),
      .oscSupplyCode(oscSupplyCode), .oscClkEnable(oscClkEnable),
      .seqHold(seqHold), .oscStartError(oscStartError));
   spi_host_model u_spi_host_model (.spiClk(spiClk), .spiCsN(spiCsN),
      .spiMosi(spiMosi), .spiMiso(spiMiso));

   // ----
   // tasks
   // ----
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic cmd(input logic [71:0] tx, input int n);
      u_spi_host_model.xfer(tx, n, rx);
   endtask
   // opcode and three no-op bytes; log lands in rx[15:0]
   task automatic read_log();
      cmd(72'h12000000, 4);
   endtask
   task automatic fire(input logic [9:0] src);
      @(negedge sys_clk) eventSrc = src;
      @(negedge sys_clk) eventSrc = 10'h000;
   endtask
   task automatic pins(input logic [2:0] exp);
      check({13'h0, eventPinOne, eventPinTwo, eventPinThree}, {13'h0, exp});
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ----
   // tests
   // ----
   initial begin
      repeat (10) @(negedge sys_clk);
      rst = 1'b0;
      repeat (4) @(negedge sys_clk);
      read_log();
      check({8'h00, rx[23:16]}, 16'h00A5);
      check(rx[15:0], 16'h0000);
      fire(10'h001);
      read_log();
      check(rx[15:0], 16'h0000);
      // enable all, pin1 <- bit0, pin2 <- bits 0,1, pin3 <- bit1
      cmd(72'h08_03FF_0001_0003_0002, 9);
      fire(10'h001);
      pins(3'h6);
      read_log();
      check(rx[15:0], 16'h0001);
      cmd(72'h02_FFFF, 3);
      pins(3'h0);
      // every source in both packet modes
      for (int m = 0; m < 2; m++) begin
         for (int b = 0; b < LOG_WIDTH; b++) begin
            @(negedge sys_clk) chirpMode = m[0];
            fire(10'h001 << b);
            read_log();
            allowed = m[0] ? ~FSK_ONLY_SOURCES : ~CHIRP_ONLY_SOURCES;
            check(rx[15:0], {6'h00, allowed & (10'h001 << b)});
            cmd(72'h02_FFFF, 3);
         end
      end
      @(negedge sys_clk) chirpMode = 1'b0;
      fire(10'h007);
      pins(3'h7);
      cmd(72'h02_FC01, 3);
      read_log();
      check(rx[15:0], 16'h0006);
      pins(3'h3);
      cmd(72'h02_0002, 3);
      pins(3'h0);
      read_log();
      check(rx[15:0], 16'h0004);
      // antenna switch takes pin two
      fire(10'h002);
      cmd(72'h9D_01, 2);
      @(negedge sys_clk) radioMode = MODE_TRANSMIT;
      repeat (2) @(negedge sys_clk);
      pins(3'h3);
      radioMode = MODE_RECEIVE;
      repeat (2) @(negedge sys_clk);
      pins(3'h1);
      cmd(72'h9D_00, 2);
      pins(3'h3);
      // oscillator supply takes pin three, two delay steps
      @(negedge sys_clk) radioMode = MODE_RC_STANDBY;
      cmd(72'h97_05_000002, 5);
      check({13'h0, oscSupplyCode}, 16'h0005);
      pins(3'h2);
      // host warms the oscillator in crystal standby first
      @(negedge sys_clk) radioMode = MODE_CRYSTAL_STANDBY;
      cnt = 0;
      while (seqHold !== 1'b1 && cnt < 20) begin
         @(negedge sys_clk) cnt++;
      end
      cnt = 0;
      while (seqHold === 1'b1 && cnt < 2000) begin
         @(negedge sys_clk) cnt++;
      end
      check({15'h0, cnt >= 625 && cnt <= 630}, 16'h0001);
      check({14'h0, oscClkEnable, oscStartError}, 16'h0002);
      pins(3'h3);
      radioMode = MODE_RC_STANDBY;
      repeat (3) @(negedge sys_clk);
      pins(3'h2);
      oscClkPresent = 1'b0;
      radioMode = MODE_TRANSMIT;
      repeat (700) @(negedge sys_clk);
      check({15'h0, oscStartError}, 16'h0001);
      radioMode = MODE_RC_STANDBY;
      cmd(72'h07, 1);
      check({15'h0, oscStartError}, 16'h0000);
      @(negedge sys_clk) coldStart = 1'b1;
      @(negedge sys_clk) coldStart = 1'b0;
      repeat (3) @(negedge sys_clk);
      check({15'h0, oscStartError}, 16'h0001);
      cmd(72'h07, 1);
      check({15'h0, oscStartError}, 16'h0000);
      tally_and_finish();
   end

   // watchdog, well beyond the expected run length
   initial begin
      #2000000;
      mismatches++;
      tally_and_finish();
   end
endmodule
